// ### dpa_top.sv
`timescale 1ns/1ps
`include "dpa_cfg.svh"
module dpa_top
  import dpa_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic por_n,
  // board straps (asynchronous pins)
  input wire logic reset_retention_select,
  input wire logic [23:0] strap_out,
  input wire logic ext_present,
  // port writes
  input wire logic wr_en,
  input wire dpa_addr_t wr_port,
  input wire dpa_byte_t wr_data,
  input wire logic dir_we,
  input wire logic [23:0] dir_data,
  // port read
  input wire logic rd_en,
  input wire dpa_addr_t rd_port,
  output dpa_byte_t rd_data,
  output logic rd_valid,
  // interrupt control
  input wire logic pat_we,
  input wire dpa_byte_t pat_data,
  input wire logic [7:0] irq_src_en,
  input wire logic [7:0] irq_src_fall,
  input wire logic pattern_en,
  input wire logic change_en,
  input wire logic [9:0] irq_clr,
  output logic [9:0] irq_flag,
  output logic irq_req,
  // field pins, main unit then extension
  input wire logic [191:0] pin_in,
  output logic [191:0] pin_out,
  output logic [191:0] pin_oe
);
  // synchronised straps
  logic keep_meta;
  logic keep;
  logic [23:0] strap_meta;
  logic [23:0] strap;
  logic ext_meta;
  logic ext_ok;

  // per-port buses, port p at bits [8p+7:8p]
  logic [191:0] line_all;
  logic [191:0] rd_all;
  logic [191:0] drv_out;
  logic [191:0] drv_oe;

  // read decode and shared reset
  logic rst_any;
  logic rd_hit;

  // interrupt history and events
  dpa_byte_t pattern;
  logic match_q;
  logic match_now;
  dpa_byte_t change_prev;
  logic [7:0] src_now;
  logic [7:0] src_prev;
  logic [7:0] src_ev;
  logic [9:0] events;
  logic [3:0] src_port [4];

  // power loss and hot reset both clear the shared logic; only the port cells tell them apart
  assign rst_any = !nrst || !por_n;

  // retention select synchroniser; it is never cleared, so the choice is settled
  // before a hot reset arrives, while power loss is handled in the port cells
  always_ff @(posedge clk_sys) begin
    keep_meta <= reset_retention_select;
    keep <= keep_meta;
  end

  // strap synchroniser; never cleared, so the power-up clear already sees the straps
  // and a strapped port leaves reset driving low rather than at the soft level
  always_ff @(posedge clk_sys) begin
    strap_meta <= strap_out;
    strap <= strap_meta;
  end

  // extension presence synchroniser; it gates writes, reads and output enables
  always_ff @(posedge clk_sys) begin
    ext_meta <= ext_present;
    ext_ok <= ext_meta;
  end

  // one port cell per byte; the extension ports sit at addresses 12..23
  // a write to an absent port is simply dropped
  for (genvar p = 0; p < `DPA_ALL_PORTS; p++) begin : g_port
    logic sel;
    assign sel = (p < `DPA_UNIT_PORTS) || ext_ok;
    dpa_port u_port (
      // clock and resets
      .clk_sys(clk_sys),
      .nrst(nrst),
      .por_n(por_n),
      // synchronised straps
      .keep(keep),
      .strap_out(strap[p]),
      // software writes, gated by mapping
      .dir_we(dir_we && sel),
      .dir_val(dir_data[p]),
      .out_we(wr_en && sel && (wr_port == 5'(p))),
      .out_val(wr_data),
      // pins
      .pin_in(pin_in[p*8 +: 8]),
      .pin_out(drv_out[p*8 +: 8]),
      .pin_oe(drv_oe[p*8 +: 8]),
      // to the shared logic
      .line(line_all[p*8 +: 8]),
      .rd_val(rd_all[p*8 +: 8])
    );
    // an absent extension never drives its pins
    assign pin_out[p*8 +: 8] = drv_out[p*8 +: 8];
    assign pin_oe[p*8 +: 8] = sel ? drv_oe[p*8 +: 8] : 8'h00;
  end

  // a read hits only a mapped port; the extension range needs the unit fitted,
  // so software probing an absent extension sees zero instead of stale latches
  assign rd_hit = (rd_port < 5'(`DPA_UNIT_PORTS)) || ((rd_port < 5'(`DPA_ALL_PORTS)) && ext_ok);

  // read strobe answered one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  // read data registered; zero on idle cycles so a stale byte never looks like an answer
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      rd_data <= 8'h00;
    end else if (rd_en && rd_hit) begin
      rd_data <= rd_all[rd_port*8 +: 8];
    end else begin
      rd_data <= 8'h00;
    end
  end

  // reference pattern held by software
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      pattern <= `DPA_PATTERN_RST;
    end else if (pat_we) begin
      pattern <= pat_data;
    end
  end

  // only the entry into a match raises the flag, so a standing match does not refire
  assign match_now = line_all[`DPA_PATTERN_MATCH_PORT*8 +: 8] == pattern;

  // match history starts true so a match already standing at release does not fire
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      match_q <= 1'b1;
    end else begin
      match_q <= match_now;
    end
  end

  // change history follows the lines even in reset; the synchronisers are never
  // cleared either, so release brings no false change
  always_ff @(posedge clk_sys) begin
    change_prev <= line_all[`DPA_STATE_CHANGE_PORT*8 +: 8];
  end

  // two lines of each irq source port; the extension carries no interrupt logic,
  // its lines only reach the read mux
  assign src_port[0] = 4'(`DPA_IRQ_SOURCE_PORT_0);
  assign src_port[1] = 4'(`DPA_IRQ_SOURCE_PORT_1);
  assign src_port[2] = 4'(`DPA_IRQ_SOURCE_PORT_2);
  assign src_port[3] = 4'(`DPA_IRQ_SOURCE_PORT_3);
  for (genvar s = 0; s < 4; s++) begin : g_src
    assign src_now[2*s] = line_all[src_port[s]*8 + `DPA_IRQ_LINE_LO];
    assign src_now[2*s+1] = line_all[src_port[s]*8 + `DPA_IRQ_LINE_HI];
  end

  // previous levels follow the lines through reset as well; with the synchronisers
  // never cleared, release brings no false edge
  always_ff @(posedge clk_sys) begin
    src_prev <= src_now;
  end

  // edge select per source: rising by default, falling when chosen;
  // both edges come from the same history, so switching the edge costs no cycle
  for (genvar e = 0; e < `DPA_IRQ_SRC_N; e++) begin : g_edge
    assign src_ev[e] = irq_src_fall[e] ? (src_prev[e] && !src_now[e])
                                       : (!src_prev[e] && src_now[e]);
  end

  // enabled source edges; a disabled source is masked here and never reaches its flag
  assign events[7:0] = src_ev & irq_src_en;

  // pattern entry; the enable gates the event, not the comparison,
  // so turning the enable on while a match stands does not fire
  assign events[`DPA_FLAG_PATTERN] = pattern_en && match_now && !match_q;

  // any line of the state change port moving, against the previous cycle
  assign events[`DPA_FLAG_CHANGE] = change_en &&
    (line_all[`DPA_STATE_CHANGE_PORT*8 +: 8] != change_prev);

  // one sticky flag per source; a new event beats a clear in the same cycle,
  // so an event that lands while software clears its flag is never lost;
  // flags of different sources stay apart so software can service each one
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      irq_flag <= 10'h000;
    end else begin
      irq_flag <= (irq_flag & ~irq_clr) | events;
    end
  end

  // a single request line for the host, high while any flag stands
  assign irq_req = |irq_flag;
endmodule

// ### dpa_cfg.svh
// Summary of operation
// - 96 lines form twelve 8-bit ports in four groups of three.
// - software sets each port input or output; direction covers all eight lines.
// - ports act as plain latched outputs and direct inputs, no handshake.
// - hot reset keeps or reverts port state per the retention select input.
// - without retention, soft ports reset to input with output latch high.
// - strapped output ports cannot become inputs and reset driving low.
// - power loss clears retained state; power-up always starts from defaults.
// - two lines of each irq source port feed interrupts, governed by control inputs.
// - several interrupt flags may pend at once, each kept separately.
// - pattern match port is compared with a loaded pattern; equality interrupts.
// - any level change on the state change port interrupts.
// - an optional extension unit of identical ports shares this interface, 192 lines.
`ifndef DPA_CFG_SVH
`define DPA_CFG_SVH

`define DPA_PORT_W 8
`define DPA_UNIT_PORTS 12
`define DPA_ALL_PORTS 24
`define DPA_ADDR_W 5
`define DPA_LINES 192
`define DPA_PATTERN_MATCH_PORT 0
`define DPA_STATE_CHANGE_PORT 1
`define DPA_IRQ_SOURCE_PORT_0 2
`define DPA_IRQ_SOURCE_PORT_1 5
`define DPA_IRQ_SOURCE_PORT_2 8
`define DPA_IRQ_SOURCE_PORT_3 11
`define DPA_IRQ_LINE_LO 0
`define DPA_IRQ_LINE_HI 4
`define DPA_IRQ_SRC_N 8
`define DPA_FLAG_N 10
`define DPA_FLAG_PATTERN 8
`define DPA_FLAG_CHANGE 9
`define DPA_SOFT_RST_OUT 8'hff
`define DPA_STRAP_RST_OUT 8'h00
`define DPA_IDLE_IN 8'hff
`define DPA_PATTERN_RST 8'h00

`endif

// ### dpa_pkg.sv
package dpa_pkg;
  typedef logic [7:0] dpa_byte_t;
  typedef logic [4:0] dpa_addr_t;
  // which interrupt flag each bit of the flag vector stands for
  typedef enum logic [3:0] {
    dpa_ev_src0_lo = 4'h0,
    dpa_ev_src0_hi = 4'h1,
    dpa_ev_src1_lo = 4'h2,
    dpa_ev_src1_hi = 4'h3,
    dpa_ev_src2_lo = 4'h4,
    dpa_ev_src2_hi = 4'h5,
    dpa_ev_src3_lo = 4'h6,
    dpa_ev_src3_hi = 4'h7,
    dpa_ev_pattern = 4'h8,
    dpa_ev_change = 4'h9
  } dpa_event_t;
endpackage

// ### dpa_port.sv
`timescale 1ns/1ps
`include "dpa_cfg.svh"
module dpa_port
  import dpa_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic por_n,
  // synchronised straps
  input wire logic keep,
  input wire logic strap_out,
  // software writes
  input wire logic dir_we,
  input wire logic dir_val,
  input wire logic out_we,
  input wire dpa_byte_t out_val,
  // pins
  input wire dpa_byte_t pin_in,
  output dpa_byte_t pin_out,
  output dpa_byte_t pin_oe,
  // to the shared logic
  output dpa_byte_t line,
  output dpa_byte_t rd_val
);
  logic is_out;
  dpa_byte_t latch;
  dpa_byte_t in_meta;
  logic clear;

  // power loss always clears; a hot reset clears only without retention
  assign clear = !por_n || (!nrst && !keep);

  // direction: a strap forces output and software cannot undo it
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      is_out <= strap_out;
    end else if (!nrst) begin
      is_out <= is_out | strap_out; // retained across hot reset
    end else if (dir_we) begin
      is_out <= dir_val | strap_out;
    end else begin
      is_out <= is_out | strap_out;
    end
  end

  // plain output latch, no strobe or handshake
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      latch <= strap_out ? `DPA_STRAP_RST_OUT : `DPA_SOFT_RST_OUT;
    end else if (nrst && out_we) begin
      latch <= out_val;
    end
  end

  // two-flop synchroniser on the field pins; it is never cleared, so the lines
  // always show the pins and no false edge or change follows a reset release
  always_ff @(posedge clk_sys) begin
    in_meta <= pin_in;
    line <= in_meta;
  end

  // read value: latched data for outputs, pin level for inputs
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      rd_val <= `DPA_IDLE_IN;
    end else begin
      rd_val <= is_out ? latch : line;
    end
  end

  assign pin_out = latch;
  assign pin_oe = {8{is_out}};
endmodule

// ### dpa_checker.sv
`timescale 1ns/1ps
module dpa_checker
  import dpa_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic por_n,
  // requests
  input wire logic [23:0] strap_out,
  input wire logic wr_en,
  input wire dpa_addr_t wr_port,
  input wire dpa_byte_t wr_data,
  input wire logic dir_we,
  input wire logic [23:0] dir_data,
  input wire logic rd_en,
  input wire logic pattern_en,
  input wire logic change_en,
  input wire logic [9:0] irq_clr,
  // answers
  input wire dpa_byte_t rd_data,
  input wire logic rd_valid,
  input wire logic [9:0] irq_flag,
  input wire logic irq_req,
  input wire logic [191:0] pin_out,
  input wire logic [191:0] pin_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst || !por_n);
  // port access: reads answer next cycle, writes and directions land next cycle
  chk_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  chk_read_idle: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
    else $error("read output while idle");
  chk_write_latch: assert property (wr_en && wr_port == 5'h00 |=> pin_out[7:0] == $past(wr_data))
    else $error("output latch not loaded");
  chk_dir_apply: assert property (dir_we && !strap_out[0] |=> pin_oe[7:0] == {8{$past(dir_data[0])}})
    else $error("direction not applied");
  // straps need a few cycles to pass their synchroniser before they bind
  chk_strap_out: assert property (strap_out[3] && $past(strap_out[3], 4) && $past(por_n, 4) |-> pin_oe[31:24] == 8'hff)
    else $error("strapped port not driving");
  // flags are sticky, summed into the request, and the pattern and change flags set only when enabled
  chk_req_sum: assert property (irq_req == (|irq_flag))
    else $error("request differs from flags");
  chk_flag_sticky: assert property (1'b1 |=> ($past(irq_flag) & ~$past(irq_clr) & ~irq_flag) == 10'h000)
    else $error("flag lost without clear");
  chk_change_gate: assert property ($rose(irq_flag[9]) |-> $past(change_en) || $past(change_en, 2))
    else $error("change flag while disabled");
  chk_match_gate: assert property ($rose(irq_flag[8]) |-> $past(pattern_en) || $past(pattern_en, 2))
    else $error("match flag while disabled");
  cover property (rd_valid && rd_data != 8'h00);
  cover property (irq_flag[8] && irq_flag[9] && irq_flag[0]);
  cover property (dir_we ##1 pin_oe[7:0] == 8'hff);
endmodule

// ### dpa_field.sv
`timescale 1ns/1ps
module dpa_field
(
  // design side
  input wire logic [191:0] pin_out,
  input wire logic [191:0] pin_oe,
  // field levels, all ones where a line is left open
  input wire logic [191:0] ext_val,
  // level seen at the pins
  output logic [191:0] pin_in
);
  // a driven line shows the latch, an open one the field level or pull-up high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ### test_digital_io_port_array_irq.sv
`timescale 1ns/1ps
module test_digital_io_port_array_irq;
  import dpa_pkg::*;
  logic clk_sys = 0, nrst = 0, por_n = 0, reset_retention_select = 0, ext_present = 1;
  logic wr_en = 0, dir_we = 0, rd_en = 0, pat_we = 0, pattern_en = 0, change_en = 0;
  logic rd_valid, irq_req;
  logic [23:0] strap_out = 24'h000008, dir_data = 0;
  dpa_addr_t wr_port = 0, rd_port = 0;
  dpa_byte_t wr_data = 0, pat_data = 0, rd_data;
  logic [7:0] irq_src_en = 0, irq_src_fall = 0;
  logic [9:0] irq_clr = 0, irq_flag;
  logic [191:0] pin_in, pin_out, pin_oe, ext_val = '1;
  dpa_byte_t lat [24];
  logic dir [24];
  int err_total = 0, comparisons = 0, seed = 40;
  dpa_top i_dut (.clk_sys, .nrst, .por_n, .reset_retention_select, .strap_out, .ext_present, .wr_en,
    .wr_port, .wr_data, .dir_we, .dir_data, .rd_en, .rd_port, .rd_data, .rd_valid, .pat_we, .pat_data,
    .irq_src_en, .irq_src_fall, .pattern_en, .change_en, .irq_clr, .irq_flag, .irq_req, .pin_in,
    .pin_out, .pin_oe);
  dpa_field i_field (.pin_out, .pin_oe, .ext_val, .pin_in);
  // free-running system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input int p, input dpa_byte_t d);
    cyc(1);
    wr_en = 1;
    wr_port = p[4:0];
    wr_data = d;
    if (p < 12 || ext_present) lat[p] = d; // an absent extension refuses the write
    cyc(1);
    wr_en = 0;
  endtask
  task automatic rd(input int p);
    dpa_byte_t e;
    e = 8'h00;
    if (p < 12 || (p < 24 && ext_present)) e = dir[p] ? lat[p] : ext_val[8*p+:8];
    cyc(1);
    rd_en = 1;
    rd_port = p[4:0];
    cyc(1);
    rd_en = 0;
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask
  task automatic pins;
    logic [191:0] eo, ep;
    foreach (lat[p]) begin
      eo[8*p+:8] = {8{dir[p] && (p < 12 || ext_present)}};
      ep[8*p+:8] = lat[p];
    end
    chk(pin_oe, eo);
    chk(pin_out, ep);
  endtask
  // the retention select must pass its synchroniser before reset is applied
  task automatic rst(input logic por);
    nrst = 0;
    por_n = !por;
    cyc(6);
    nrst = 1;
    por_n = 1;
    if (por || !reset_retention_select) foreach (dir[p]) begin
      dir[p] = strap_out[p];
      lat[p] = strap_out[p] ? 8'h00 : 8'hff;
    end
    cyc(4);
  endtask
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    #200000;
    err_total++;
    summarize;
  end
  // main sequence
  initial begin
    rst(1);
    pins;
    rd(0);
    rd(3);
    for (int p = 0; p < 24; p++) wr(p, 8'($random(seed)));
    cyc(1);
    dir_we = 1;
    dir_data = 24'($random(seed)) & 24'hfffff7; // a zero on the strapped port must be ignored
    foreach (dir[p]) dir[p] = dir_data[p] | strap_out[p];
    ext_val = {6{32'($random(seed))}};
    cyc(1);
    dir_we = 0;
    cyc(5);
    pins;
    for (int p = 0; p < 24; p++) rd(p);
    ext_present = 0; // absent extension: writes refused, reads zero, pins released
    cyc(3);
    wr(12, 8'($random(seed)));
    rd(12);
    rd(26); // unmapped port
    pins;
    ext_present = 1;
    reset_retention_select = 1;
    cyc(3);
    rst(0);
    pins;
    reset_retention_select = 0;
    cyc(3);
    rst(0);
    pins;
    wr(0, 8'h5a);
    reset_retention_select = 1;
    cyc(3);
    rst(1);
    pins;
    ext_val = '1;
    reset_retention_select = 0;
    cyc(3);
    rst(0);
    pattern_en = 1;
    change_en = 1;
    irq_src_en = 8'h81;
    irq_src_fall = 8'h01;
    pat_data = 8'($random(seed)) & 8'h7f;
    pat_we = 1;
    cyc(1);
    pat_we = 0;
    cyc(4);
    chk(irq_flag, 10'h000);
    ext_val[7:0] = pat_data;
    ext_val[9] = 0;
    ext_val[16] = 0;
    ext_val[20] = 0; // line of a disabled source
    cyc(6);
    chk(irq_flag, 10'h301);
    chk(irq_req, 1'b1);
    irq_clr = 10'h100;
    cyc(1);
    irq_clr = 0;
    ext_val[92] = 0; // falling edge, source set for rising
    cyc(6);
    ext_val[92] = 1;
    cyc(6);
    chk(irq_flag, 10'h281);
    irq_clr = '1;
    cyc(1);
    irq_clr = 0;
    cyc(1);
    chk(irq_req, 1'b0);
    summarize;
  end
endmodule
bind dpa_top dpa_checker i_chk (.clk_sys, .nrst, .por_n, .strap_out, .wr_en, .wr_port, .wr_data, .dir_we,
  .dir_data, .rd_en, .pattern_en, .change_en, .irq_clr, .rd_data, .rd_valid, .irq_flag, .irq_req,
  .pin_out, .pin_oe);
